// >>> stbsc_pkg.sv
// Constants, phase codes and helper functions for the target bus signal control block.
// Assumes a 100 MHz system clock; all times are converted to cycles here.
package stbsc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // Phase lines must be valid this long before the first REQ of a phase.
  localparam int BUS_SETTLE_NS = 400;
  // Data must stand on the bus this long before REQ in transfers toward the initiator; the code gives 4 cycles (40 ns).
  localparam int DESKEW_NS = 45;
  // Longest allowed time from seeing our selection to asserting BSY.
  localparam int BSY_RESPONSE_NS = 150;

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((BUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DESKEW_CYC =
    CNT_W'((DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BSY_RESPONSE_CYC =
    CNT_W'(BSY_RESPONSE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  localparam int DATA_W = 8;
  localparam int ID_W = 3;
  localparam int MAX_DEVICES = 8;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

  // Phase code on {MSG, C/D, I/O}.
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_DATA_IN = 3'h1;
  localparam logic [2:0] PH_COMMAND = 3'h2;
  localparam logic [2:0] PH_STATUS = 3'h3;
  localparam logic [2:0] PH_MESSAGE_IN = 3'h7;
  localparam int PH_MSG_BIT = 2;
  localparam int PH_CD_BIT = 1;
  localparam int PH_IO_BIT = 0;

  typedef enum logic [3:0] {
    ST_FREE,
    ST_SELECT,
    ST_SELECTED,
    ST_HOLD,
    ST_SETTLE,
    ST_TXWAIT,
    ST_DESKEW,
    ST_REQ,
    ST_ACKLOW
  } stbsc_state_t;

  // Codes with MSG true other than message-in are reserved.
  function automatic logic phaseReserved(input logic [2:0] code);
    phaseReserved = code[PH_MSG_BIT] && (code != PH_MESSAGE_IN);
  endfunction

  // One data line per bus identity.
  function automatic logic [DATA_W-1:0] idToBit(input logic [ID_W-1:0] id);
    idToBit = BYTE_ONE << id;
  endfunction

endpackage

// >>> stbsc_buf2.sv
// Two-entry buffer with valid and ready on both sides for received bytes.
// Assumes one clock and a synchronous active-high reset; all outputs are flops.
`timescale 1ns/1ps
module stbsc_buf2
  import stbsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [DATA_W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [DATA_W-1:0] outData
);

  logic [DATA_W-1:0] head_r;
  logic [DATA_W-1:0] spare_r;
  logic headValid_r;
  logic spareValid_r;
  logic push;
  logic pop;

  // Ready drops as soon as the spare slot is taken, so it is a pure flop output.
  assign inReady = !spareValid_r;
  assign outValid = headValid_r;
  assign outData = head_r;
  assign push = inValid && !spareValid_r;
  assign pop = headValid_r && outReady;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      headValid_r <= 1'b0;
      spareValid_r <= 1'b0;
    end else if (spareValid_r) begin
      if (pop) begin
        spareValid_r <= 1'b0;
      end
    end else if (push) begin
      if (headValid_r && !pop) begin
        spareValid_r <= 1'b1;
      end else begin
        headValid_r <= 1'b1;
      end
    end else if (pop) begin
      headValid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      head_r <= BYTE_ZERO;
      spare_r <= BYTE_ZERO;
    end else if (spareValid_r) begin
      if (pop) begin
        head_r <= spare_r;
      end
    end else if (push) begin
      if (headValid_r && !pop) begin
        spare_r <= inData;
      end else begin
        head_r <= inData;
      end
    end
  end

endmodule

// >>> stbsc_top.sv
// Target-side signal control for an 8-bit asynchronous parallel peripheral bus.
// Assumes bus inputs arrive already synchronised, in true-sense (1 = asserted),
// and that pads turn each out/oe pair into an open-collector active-low driver.
// What this block does
// (R1) One initiator and one target talk at a time; at most eight devices.
// (R2) Own bus identity comes from a strap captured after reset, never from writes.
// (R3) Identity n is signalled by data line n alone.
// (R4) Act only as target; never drive SEL or select anyone.
// (R5) Initiator selects; this drive requests every command, data, status, message byte.
// (R6) Each completed REQ/ACK handshake moves exactly one byte.
// (R7) BSY is wired-OR and true whenever any device uses the bus.
// (R8) Drive alone drives C/D; true means control, false means data.
// (R9) Drive drives I/O; true means toward initiator, false means toward drive.
// (R10) Drive drives MSG to mark message phase.
// (R11) Drive asserts REQ to ask for each byte.
// (R12) Initiator drives ACK to acknowledge each requested byte.
// (R13) RST is wired-OR; only sampled and acted on, never driven.
// (R14) Data byte has line 7 as MSB; true line means one.
// (R15) Lines go true only by asserting, false only by releasing.
// (R16) Every output not asserting stays released.
// (R17) Bus free: sample BSY, SEL, RST; leave phase lines, REQ and data alone.
// (R18) Selection entered on SEL true; sample SEL, BSY, data, RST only.
// (R19) When our identity bit is seen with SEL, assert BSY.
// (R20) Transfer phases: drive BSY, C/D, I/O, MSG, REQ; sample ACK, RST; ignore SEL.
// (R21) Drive data in data-in, status, message; sample in command and data-out.
// (R22) Bus is free whenever SEL, BSY and RST are all false.
// (R23) Only codes 000, 001, 010, 011, 111 are driven on MSG, C/D, I/O.
// (R24) BSY asserted within 150 ns of detecting identity bit with SEL.
`timescale 1ns/1ps
module stbsc_top
  import stbsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ID_W-1:0] targetIdStrap,
  input wire logic bsyIn,
  output logic bsyOut,
  output logic bsyOe,
  input wire logic selIn,
  input wire logic rstIn,
  input wire logic ackIn,
  output logic cdOut,
  output logic cdOe,
  output logic ioOut,
  output logic ioOe,
  output logic msgOut,
  output logic msgOe,
  output logic reqOut,
  output logic reqOe,
  input wire logic [DATA_W-1:0] dbIn,
  output logic [DATA_W-1:0] dbOut,
  output logic [DATA_W-1:0] dbOe,
  input wire logic phaseValid,
  input wire logic [2:0] phaseCode,
  input wire logic releaseReq,
  output logic cmdDone,
  output logic cmdReject,
  input wire logic txValid,
  output logic txReady,
  input wire logic [DATA_W-1:0] txData,
  output logic rxValid,
  input wire logic rxReady,
  output logic [DATA_W-1:0] rxData,
  output logic selected,
  output logic busFree,
  output logic busReset,
  output logic [2:0] phaseNow
);

  stbsc_state_t state_r;
  logic [ID_W-1:0] myId_r;
  logic strapTaken_r;
  logic lineOn_r;
  logic bsyOe_r;
  logic [2:0] phase_r;
  logic phaseSet_r;
  logic reqOe_r;
  logic [DATA_W-1:0] dbData_r;
  logic dbDrive_r;
  logic [CNT_W-1:0] count_r;
  logic txReady_r;
  logic cmdDone_r;
  logic cmdReject_r;
  logic selected_r;
  logic busFree_r;
  logic busReset_r;
  logic rxPush;
  logic rxInReady;
  logic idSeen;
  logic phaseInfo;
  logic dropBus;
  logic cdOe_r;
  logic ioOe_r;
  logic msgOe_r;
  logic [DATA_W-1:0] dbOe_r;

  // A single flop supplies the asserted level of BSY, C/D, I/O, MSG and REQ; the data lines take dbData_r.
  assign bsyOut = lineOn_r;
  assign cdOut = lineOn_r;
  assign ioOut = lineOn_r;
  assign msgOut = lineOn_r;
  assign reqOut = lineOn_r;
  assign bsyOe = bsyOe_r;
  assign reqOe = reqOe_r;
  // Phase lines are only driven while holding the bus in a transfer phase.
  assign phaseInfo = phaseSet_r && bsyOe_r && !dropBus;
  // A release drops the phase lines on the same edge as BSY, never one cycle later.
  assign dropBus = (state_r == ST_HOLD) && releaseReq; // [R16]
  assign cdOe = cdOe_r;
  assign ioOe = ioOe_r;
  assign msgOe = msgOe_r;
  assign dbOut = dbData_r;
  assign dbOe = dbOe_r;
  assign txReady = txReady_r;
  assign cmdDone = cmdDone_r;
  assign cmdReject = cmdReject_r;
  assign selected = selected_r;
  assign busFree = busFree_r;
  assign busReset = busReset_r;
  assign phaseNow = phase_r;

  // The strap is read one cycle after reset release, so a write path cannot alter it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      myId_r <= {ID_W{1'b0}};
      strapTaken_r <= 1'b0;
      lineOn_r <= 1'b0;
    end else begin
      lineOn_r <= 1'b1;
      if (!strapTaken_r) begin
        myId_r <= targetIdStrap; // [R2]
        strapTaken_r <= 1'b1;
      end
    end
  end

  // Our identity bit alone decides selection; another asserted bit is the initiator.
  assign idSeen = strapTaken_r && selIn && ((dbIn & idToBit(myId_r)) != BYTE_ZERO); // [R3] [R18]

  // Observed bus state; RST is only ever read.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busFree_r <= 1'b0;
      busReset_r <= 1'b0;
    end else begin
      busFree_r <= !selIn && !bsyIn && !rstIn; // [R22] [R7] [R17]
      busReset_r <= rstIn; // [R13]
    end
  end

  // The byte from the initiator is captured on the edge that first sees ACK.
  assign rxPush = (state_r == ST_REQ) && ackIn && !phase_r[PH_IO_BIT]; // [R6] [R21]

  always_ff @(posedge mclk) begin
    if (sys_rst || rstIn) begin
      state_r <= ST_FREE; // [R13]
      bsyOe_r <= 1'b0;
      reqOe_r <= 1'b0;
      phaseSet_r <= 1'b0;
      phase_r <= PH_DATA_OUT;
      dbDrive_r <= 1'b0;
      dbData_r <= BYTE_ZERO;
      count_r <= CNT_ZERO;
      txReady_r <= 1'b0;
      cmdDone_r <= 1'b0;
      cmdReject_r <= 1'b0;
      selected_r <= 1'b0;
    end else begin
      cmdDone_r <= 1'b0;
      cmdReject_r <= 1'b0;
      case (state_r)
        ST_FREE: begin
          // Only SEL, BSY and RST matter here; the drive never starts a selection.
          if (selIn && strapTaken_r) begin
            state_r <= ST_SELECT; // [R18] [R4] [R17]
          end
        end
        ST_SELECT: begin
          if (idSeen && !bsyIn) begin
            // One cycle from detection, well inside the response limit.
            bsyOe_r <= 1'b1; // [R19] [R24] [R1]
            selected_r <= 1'b1;
            state_r <= ST_SELECTED;
          end else if (!selIn) begin
            // Another target was chosen; wait for the initiator to end selection.
            state_r <= ST_FREE;
          end
        end
        ST_SELECTED: begin
          if (!selIn) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // SEL is ignored while holding the bus.
          if (releaseReq) begin
            bsyOe_r <= 1'b0; // [R16]
            phaseSet_r <= 1'b0;
            selected_r <= 1'b0;
            cmdDone_r <= 1'b1;
            state_r <= ST_FREE;
          end else if (phaseValid) begin
            if (phaseReserved(phaseCode)) begin
              cmdReject_r <= 1'b1; // [R23]
            end else begin
              phase_r <= phaseCode; // [R8] [R9] [R10] [R20]
              phaseSet_r <= 1'b1;
              cmdDone_r <= 1'b1;
              count_r <= SETTLE_CYC;
              state_r <= ST_SETTLE;
            end
          end else if (phaseSet_r && phase_r[PH_IO_BIT]) begin
            txReady_r <= 1'b1;
            state_r <= ST_TXWAIT;
          end else if (phaseSet_r && rxInReady) begin
            // REQ is only raised with room for the byte, so a stalled reader loses nothing.
            reqOe_r <= 1'b1; // [R11] [R5]
            state_r <= ST_REQ;
          end
        end
        ST_SETTLE: begin
          // Settle runs after every accepted phase, even a repeat of the same code.
          if (count_r == CNT_ONE) begin
            state_r <= ST_HOLD;
          end
          count_r <= count_r - CNT_ONE;
        end
        ST_TXWAIT: begin
          if (txValid && txReady_r) begin
            txReady_r <= 1'b0;
            dbData_r <= txData; // [R14]
            dbDrive_r <= 1'b1; // [R21]
            count_r <= DESKEW_CYC;
            state_r <= ST_DESKEW;
          end else if (phaseValid || releaseReq) begin
            // Nothing is on the bus yet, so a new command may abandon the wait.
            txReady_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_DESKEW: begin
          if (count_r == CNT_ONE) begin
            reqOe_r <= 1'b1; // [R11]
            state_r <= ST_REQ;
          end
          count_r <= count_r - CNT_ONE;
        end
        ST_REQ: begin
          // The initiator may take any time to answer; only RST or sys_rst clears a hung request.
          if (ackIn) begin // [R12]
            reqOe_r <= 1'b0;
            state_r <= ST_ACKLOW;
          end
        end
        ST_ACKLOW: begin
          // Data stays on the bus until ACK falls, so the initiator reads a stable byte.
          if (!ackIn) begin
            dbDrive_r <= 1'b0; // [R16]
            state_r <= ST_HOLD;
          end
        end
        default: begin
          state_r <= ST_FREE;
        end
      endcase
    end
  end

  // Open-collector drive: only true lines are asserted, everything else is released.
  always_ff @(posedge mclk) begin
    if (sys_rst || rstIn) begin
      cdOe_r <= 1'b0;
      ioOe_r <= 1'b0;
      msgOe_r <= 1'b0;
      dbOe_r <= BYTE_ZERO;
    end else begin
      cdOe_r <= phaseInfo && phase_r[PH_CD_BIT]; // [R15] [R8]
      ioOe_r <= phaseInfo && phase_r[PH_IO_BIT]; // [R9]
      msgOe_r <= phaseInfo && phase_r[PH_MSG_BIT]; // [R10]
      if (dbDrive_r && phase_r[PH_IO_BIT]) begin
        dbOe_r <= dbData_r; // [R15] [R14]
      end else begin
        dbOe_r <= BYTE_ZERO;
      end
    end
  end

  stbsc_buf2 u_rxbuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(rxPush),
    .inReady(rxInReady),
    .inData(dbIn),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

endmodule

// >>> stbsc_sva.sv
// Checker for the target bus signal control block.
// Bound to stbsc_top and sees only the ports of that module.
`timescale 1ns/1ps
module stbsc_sva
  import stbsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ID_W-1:0] targetIdStrap,
  input wire logic bsyIn,
  input wire logic bsyOe,
  input wire logic selIn,
  input wire logic rstIn,
  input wire logic ackIn,
  input wire logic cdOe,
  input wire logic ioOe,
  input wire logic msgOe,
  input wire logic reqOe,
  input wire logic [DATA_W-1:0] dbIn,
  input wire logic [DATA_W-1:0] dbOut,
  input wire logic [DATA_W-1:0] dbOe,
  input wire logic phaseValid,
  input wire logic [2:0] phaseCode,
  input wire logic cmdReject
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  wire logic [DATA_W-1:0] ownBit = 8'h01 << targetIdStrap;
  sequence ownSel;
    selIn && !rstIn && !bsyIn && (dbIn & ownBit) != 8'h00;
  endsequence
  sequence bsyWithin;
    ##[1:3] bsyOe;
  endsequence
  bsy_response_a: assert property (
    ownSel |-> bsyWithin) else $error("BSY late after selection.");
  idle_released_a: assert property (
    !bsyOe |-> {cdOe, ioOe, msgOe, reqOe, dbOe} == 12'h000) else $error("Line driven while idle.");
  reset_release_a: assert property (
    rstIn |=> !bsyOe && !reqOe && dbOe == 8'h00) else $error("Lines held through bus reset.");
  reserved_refuse_a: assert property (
    cmdReject |-> $past(phaseValid) && $past(phaseCode) inside {3'h4, 3'h5, 3'h6})
    else $error("Wrong refusal.");
  phase_bsy_a: assert property (
    cdOe || ioOe || msgOe || reqOe |-> bsyOe) else $error("Phase line without BSY.");
  msg_code_a: assert property (
    msgOe |-> cdOe && ioOe) else $error("Reserved phase code driven.");
  data_dir_a: assert property (
    dbOe != 8'h00 |-> ioOe && (dbOe & ~dbOut) == 8'h00) else $error("Data driven wrongly.");
  req_ack_a: assert property (
    reqOe && ackIn |=> !reqOe) else $error("REQ held after ACK.");
endmodule
bind stbsc_top stbsc_sva u_sva (.mclk, .sys_rst, .targetIdStrap, .bsyIn, .bsyOe, .selIn,
  .rstIn, .ackIn, .cdOe, .ioOe, .msgOe, .reqOe, .dbIn, .dbOut, .dbOe, .phaseValid,
  .phaseCode, .cmdReject);

// >>> stbsc_host.sv
// Initiator model: answers each target REQ with ACK after dly cycles.
// Assumes true-sense levels where a released line reads false.
`timescale 1ns/1ps
module stbsc_host
  import stbsc_pkg::*;
(
  input wire logic mclk,
  input wire logic req,
  input wire logic io,
  input wire logic [DATA_W-1:0] db,
  input wire logic [6:0] dly,
  output logic ack,
  output logic [DATA_W-1:0] drv,
  output logic [DATA_W-1:0] got,
  output logic gotStb
);
  int w = 0;
  logic [DATA_W-1:0] n = 8'h00;
  initial begin
    ack = 1'b0;
    drv = 8'h00;
    got = 8'h00;
    gotStb = 1'b0;
  end
  // There is no time limit on the answer, so a long dly tests a target that must wait.
  always @(posedge mclk) begin
    #1;
    gotStb = 1'b0;
    if (!req) begin
      ack = 1'b0;
      drv = 8'h00;
      w = dly;
    end else if (!ack) begin
      if (!io) drv = 8'h5A ^ n;
      if (w > 1) begin
        w--;
      end else begin
        ack = 1'b1;
        got = db;
        gotStb = io;
        n = io ? n : n + 8'h01;
      end
    end
  end
endmodule

// >>> stbsc_top_test.sv
// Self-checking bench for stbsc_top with an initiator model and the bound checker.
// Assumes stbsc_pkg, stbsc_host and stbsc_sva are compiled first.
`timescale 1ns/1ps
module stbsc_top_test
  import stbsc_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ID_W-1:0] targetIdStrap;
  logic bsyIn, bsyOut, bsyOe, selIn, rstIn, ackIn, cdOut, cdOe, ioOut, ioOe, msgOut, msgOe;
  logic reqOut, reqOe, phaseValid, releaseReq, cmdDone, cmdReject, txValid, txReady;
  logic rxValid, rxReady, selected, busFree, busReset, stall, gotStb;
  logic [DATA_W-1:0] dbIn, dbOut, dbOe, txData, rxData, selDb, drv, got, own, other;
  logic [2:0] phaseCode, phaseNow, prev;
  logic [6:0] dly;
  logic [DATA_W-1:0] expQ[$];
  int bad_count = 0;
  int n_tests = 0;
  int rxN = 0;
  int n0;

  always #5 mclk = ~mclk;
  // Released lines read false, so each wire is the OR of its asserting drivers.
  assign bsyIn = bsyOe & bsyOut;
  assign dbIn = (dbOe & dbOut) | drv | selDb;
  always @(posedge mclk) rxReady <= #1 !stall && ($urandom % 4 != 0);

  stbsc_top u_dut (.mclk, .sys_rst, .targetIdStrap, .bsyIn, .bsyOut, .bsyOe, .selIn, .rstIn,
    .ackIn, .cdOut, .cdOe, .ioOut, .ioOe, .msgOut, .msgOe, .reqOut, .reqOe, .dbIn, .dbOut,
    .dbOe, .phaseValid, .phaseCode, .releaseReq, .cmdDone, .cmdReject, .txValid, .txReady,
    .txData, .rxValid, .rxReady, .rxData, .selected, .busFree, .busReset, .phaseNow);
  stbsc_host u_host (.mclk, .req(reqOe & reqOut), .io(ioOe & ioOut), .db(dbIn), .dly,
    .ack(ackIn), .drv, .got, .gotStb);

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(input logic rel, input logic [2:0] c);
    int k;
    k = 0;
    releaseReq = rel;
    phaseValid = !rel;
    phaseCode = c;
    while (!cmdDone && !cmdReject && k < 2000) begin
      tick(1);
      k++;
    end
    check({7'h00, k < 2000}, 8'h01);
    check({7'h00, cmdReject}, {7'h00, !rel && c[2] && c != 3'h7});
    releaseReq = 1'b0;
    phaseValid = 1'b0;
    tick(2);
  endtask
  task automatic select(input logic [7:0] ids, input logic hit);
    selDb = ids;
    tick(1);
    selIn = 1'b1;
    tick(3);
    check({6'h00, bsyOe, selected}, {6'h00, hit, hit});
    selIn = 1'b0;
    selDb = 8'h00;
    tick(2);
  endtask
  task automatic sendByte(input logic [7:0] b);
    int k;
    k = 0;
    txValid = 1'b1;
    txData = b;
    while (!txReady && k < 2000) begin
      tick(1);
      k++;
    end
    check({7'h00, k < 2000}, 8'h01);
    tick(1);
    txValid = 1'b0;
    expQ.push_back(b);
  endtask

  always @(negedge mclk) begin
    if (rxValid && rxReady) begin
      check(rxData, 8'h5A ^ rxN[7:0]);
      rxN++;
    end
    if (gotStb) check(got, expQ.pop_front());
  end

  initial begin
    {selIn, rstIn, phaseValid, releaseReq, txValid, stall} = 6'h00;
    {selDb, txData, phaseCode, prev, dly} = 29'h00000001;
    void'($urandom(54997));
    targetIdStrap = 3'($urandom % 8);
    own = 8'h01 << targetIdStrap;
    other = 8'h01 << 3'(targetIdStrap + 3'h1);
    tick(2);
    sys_rst = 1'b0;
    tick(3);
    select(other, 1'b0);
    select(own | other, 1'b1);
    for (int c = 0; c < 8; c++) begin
      dly = 7'(1 + $urandom % 4);
      stall = (c == 0);
      n0 = rxN;
      cmd(1'b0, 3'(c));
      if (!(c >= 4 && c <= 6)) prev = 3'(c);
      tick(100);
      check({5'h00, phaseNow}, {5'h00, prev});
      check({4'h0, bsyOe, msgOe, cdOe, ioOe}, {5'h01, prev});
      if (c == 0) begin
        // A full buffer must hold off REQ rather than drop a byte.
        check({7'h00, reqOe}, 8'h00);
        check(8'(rxN - n0), 8'h00);
        stall = 1'b0;
        tick(60);
      end
      if (prev[0]) begin
        repeat (2) sendByte(8'($urandom));
        tick(40);
      end else begin
        check({7'h00, rxN > n0}, 8'h01);
      end
    end
    check(8'(expQ.size()), 8'h00);
    cmd(1'b1, 3'h0);
    tick(3);
    check({6'h00, bsyOe, busFree}, 8'h01);
    select(own, 1'b1);
    cmd(1'b0, 3'h1);
    dly = 7'h3C;
    tick(45);
    sendByte(8'hC3);
    tick(10);
    rstIn = 1'b1;
    tick(2);
    check({3'h0, bsyOe, cdOe, ioOe, msgOe, reqOe}, 8'h00);
    check({6'h00, busReset, selected}, 8'h02);
    rstIn = 1'b0;
    expQ.delete();
    tick(3);
    tally_and_finish;
  end

  // Allows roughly twenty times the expected length of the run.
  initial begin
    #300000;
    bad_count++;
    tally_and_finish;
  end
endmodule
